//--- bench/dcs_mem_model.sv
// Word memory on the far side of the transfer port.
// Assumes a request held until ack; slow_in adds a wait cycle.
`timescale 1ns/100ps
module dcs_mem_model (
   input  wire logic        clk_in,   // Clock
   input  wire logic        req_in,   // Request
   input  wire logic        we_in,    // Write
   input  wire logic [31:0] addr_in,  // Address
   input  wire logic [31:0] wdata_in, // Write data
   input  wire logic        slow_in,  // Answer slowly
   output logic             ack_out,  // Done pulse
   output logic [31:0]      rdata_out // Read data
);
   logic [31:0] mem [logic [31:0]];
   logic        wait_q = 1'b0;
   initial ack_out = 1'b0;
   initial rdata_out = 32'h0;
   always @(posedge clk_in)
   begin
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out;
      if (req_in && !ack_out && slow_in && !wait_q)
         wait_q <= 1'b1;
      else if (req_in && !ack_out)
      begin
         wait_q <= 1'b0;
         ack_out <= 1'b1;
         if (we_in)
            mem[addr_in] = wdata_in;
         else
            rdata_out <= mem.exists(addr_in) ? mem[addr_in] : 32'h0;
      end
   end
endmodule

//--- bench/dcs_top_asserts.sv
// Port-level checks of the register bus and memory port.
// Assumes it is bound to every dcs_top instance.
`timescale 1ns/100ps
module dcs_top_asserts (
   input wire logic        clk_in,            // Clock
   input wire logic        rst_in,            // Reset
   input wire logic        s_axi_awready_out, // Aw ready
   input wire logic        s_axi_wready_out,  // W ready
   input wire logic        s_axi_bvalid_out,  // B valid
   input wire logic        s_axi_bready_in,   // B ready
   input wire logic        s_axi_arvalid_in,  // Ar valid
   input wire logic        s_axi_arready_out, // Ar ready
   input wire logic        s_axi_rvalid_out,  // R valid
   input wire logic        s_axi_rready_in,   // R ready
   input wire logic [31:0] s_axi_rdata_out,   // R data
   input wire logic        mem_req_out,       // Mem request
   input wire logic        mem_we_out,        // Mem write
   input wire logic [31:0] mem_addr_out,      // Mem address
   input wire logic        mem_ack_in         // Mem done
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
      else $error("write response dropped");
   a_bresp_drop: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
      else $error("write response repeated");
   a_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
      |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data moved");
   a_one_read: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
      else $error("read taken while busy");
   a_one_write: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
      else $error("write taken while busy");
   a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
      else $error("read answer late");
   a_mem_hold: assert property (mem_req_out && !mem_ack_in |=> mem_req_out
      && $stable(mem_addr_out) && $stable(mem_we_out)) else $error("memory request moved");
   a_reset_quiet: assert property ($fell(rst_in) |-> !mem_req_out && !s_axi_bvalid_out)
      else $error("busy after reset");
endmodule
bind dcs_top dcs_top_asserts chk (.*);

//--- bench/test_dma_channel_setup_and_crc.sv
// Self-checking bench: registers, one block transfer, checksum modes.
// Assumes dcs_top, dcs_mem_model and the bound checker.
`timescale 1ns/100ps
`include "dcs_cfg.svh"
module test_dma_channel_setup_and_crc;
   logic        clk_in = 0, rst_in = 1, slow = 0, mem_ack_in, mem_req_out, mem_we_out;
   logic        s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
   logic        s_axi_arvalid_in = 0, s_axi_rready_in = 0, s_axi_awready_out;
   logic        s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
   logic [7:0]  s_axi_awaddr_in = 0, s_axi_araddr_in = 0, trig_in = 0;
   logic [31:0] s_axi_wdata_in = 0, s_axi_rdata_out, mem_addr_out, mem_wdata_out, mem_rdata_in;
   logic [3:0]  s_axi_wstrb_in = 4'hf;
   logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, mem_size_out, rsp;
   logic [31:0] rd, s0;
   int          err_total = 0, check_count = 0;
   dcs_top uut (.*);
   dcs_mem_model mdl (.clk_in(clk_in), .req_in(mem_req_out), .we_in(mem_we_out),
      .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .slow_in(slow),
      .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));
   always #50 clk_in = ~clk_in;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      {s_axi_awaddr_in, s_axi_wdata_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in}
         <= {a, d, 3'b111};
      do
      begin
         @(posedge clk_in);
         if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
         if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      end
      while (s_axi_bvalid_out !== 1'b1);
      rsp = s_axi_bresp_out;
      s_axi_bready_in <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_in);
      {s_axi_araddr_in, s_axi_arvalid_in, s_axi_rready_in} <= {a, 2'b11};
      do
      begin
         @(posedge clk_in);
         if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      end
      while (s_axi_rvalid_out !== 1'b1);
      {d, rsp} = {s_axi_rdata_out, s_axi_rresp_out};
      s_axi_rready_in <= 1'b0;
   endtask
   function automatic logic [31:0] crc_ref(input logic p, input int n);
      logic [31:0] c;
      logic [7:0]  b;
      c = p ? 32'hffffffff : 32'h0000ffff;
      for (int i = 0; i < n; i++)
      begin
         b = 8'(32'h34333231 >> (8 * i));
         c = p ? c ^ {24'h0, b} : c ^ {16'h0, b, 8'h0};
         repeat (8) c = p ? (c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1)
                          : (c[15] ? (c << 1) ^ 32'h1021 : c << 1) & 32'hffff;
      end
      return c;
   endfunction
   task automatic t_regs;
      axw(`DCS_OFF_DESC, 32'h100);
      axw(`DCS_OFF_WB, 32'h180);
      axw(`DCS_OFF_CTRL, 32'h1);
      axw(`DCS_OFF_DESC, 32'h500);
      axr(`DCS_OFF_DESC, rd);
      chk(rd, 32'h100);
      axw(8'h20, 32'h1);
      chk({30'h0, rsp}, 32'h2);
      axr(8'h20, rd);
      chk({30'h0, rsp}, 32'h2);
      $display("t_regs done");
   endtask
   task automatic t_xfer;
      logic [31:0] dsc [6] = '{32'h201, 32'h2, 32'h200, 32'h300, 32'hcafe0001, 32'h5a5a0002};
      for (int i = 0; i < 6; i++) mdl.mem[(i < 4 ? 32'h100 : 32'h1f0) + 4 * i] = dsc[i];
      slow <= 1'b1;
      axw(`DCS_OFF_CHCFG, 32'h303);
      axr(`DCS_OFF_CHCFG, rd);
      chk(rd, 32'h303);
      axw(`DCS_OFF_CTRL, 32'h101);
      trig_in <= 8'h04;
      repeat (20) @(posedge clk_in);
      chk(mdl.mem.exists(32'h300), 32'h0);
      axw(`DCS_OFF_CTRL, 32'h1);
      trig_in <= 8'h0c;
      repeat (20) @(posedge clk_in);
      chk(mdl.mem.exists(32'h300), 32'h0);
      axw(`DCS_OFF_CTRL, 32'h101);
      rd = 32'h0;
      for (int n = 0; n < 50 && rd[0] !== 1'b1; n++) axr(`DCS_OFF_PENDING, rd);
      chk(rd, 32'h1);
      chk(mdl.mem[32'h300], dsc[4]);
      chk(mdl.mem[32'h304], dsc[5]);
      chk(mdl.mem.exists(32'h308), 32'h0);
      chk(mdl.mem[32'h184], 32'h0);
      axw(`DCS_OFF_CHCFG, 32'h0);
      axr(`DCS_OFF_PENDING, rd);
      chk(rd, 32'h0);
      $display("t_xfer done");
   endtask
   task automatic t_crc;
      logic [31:0] mode [6] = '{32'h100, 32'h101, 32'h102, 32'h104, 32'h10c, 32'h103};
      for (int k = 0; k < 6; k++)
      begin
         axw(`DCS_OFF_CRC_CTRL, 32'h0);
         axw(`DCS_OFF_CRC_CTRL, mode[k]);
         axr(`DCS_OFF_CRC_SUM, s0);
         axw(`DCS_OFF_CRC_DATA, 32'h34333231);
         axr(`DCS_OFF_CRC_SUM, rd);
         if (k < 4)
            chk(rd & (k == 3 ? 32'hffffffff : 32'hffff),
               crc_ref(k == 3, k == 3 ? 1 : 1 << k));
         else
            chk(rd, s0);
      end
      $display("t_crc done");
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      #2000000;
      err_total++;
      final_report;
   end
   initial
   begin
      repeat (16) @(posedge clk_in);
      rst_in <= 1'b0;
      t_regs;
      t_xfer;
      t_crc;
      final_report;
   end
endmodule

//--- rtl/dcs_cfg.svh
// Offsets, field positions, reset values and constants of the channel setup block.
// Assumes a 32-bit register bus with one aligned word per register.
`ifndef DCS_CFG_SVH
`define DCS_CFG_SVH

// ==========================================
// Register byte offsets
`define DCS_OFF_CTRL     8'h00
`define DCS_OFF_CRC_CTRL 8'h04
`define DCS_OFF_CRC_DATA 8'h08
`define DCS_OFF_CRC_SUM  8'h0c
`define DCS_OFF_DESC     8'h10
`define DCS_OFF_WB       8'h14
`define DCS_OFF_CHCFG    8'h18
`define DCS_OFF_STATUS   8'h1c
`define DCS_OFF_PENDING  8'h24

// ==========================================
// Global control fields
`define DCS_CTRL_ON      0
`define DCS_CTRL_LVL_LO  8
`define DCS_CTRL_LVL_HI  11

// ==========================================
// channel_control_a fields
`define DCS_CCA_EN       0
`define DCS_CCA_IE       1
`define DCS_CCA_ACT      2
`define DCS_CCA_SRC_LO   8
`define DCS_CCA_SRC_HI   10
`define DCS_CCA_LVL_LO   16
`define DCS_CCA_LVL_HI   17
`define DCS_CCA_SEL_LO   24
`define DCS_CCA_SEL_HI   25

// ==========================================
// checksum_control fields and codes
`define DCS_CRC_W_LO     0
`define DCS_CRC_W_HI     1
`define DCS_CRC_P_LO     2
`define DCS_CRC_P_HI     3
`define DCS_CRC_SRC      4
`define DCS_CRC_EN       8
`define DCS_POLY_CCITT   2'h0
`define DCS_POLY_ETH     2'h1
`define DCS_W_BYTE       2'h0
`define DCS_W_HALF       2'h1
`define DCS_W_WORD       2'h2
`define DCS_W_RSVD       2'h3
`define DCS_CRC16_POLY   16'h1021
`define DCS_CRC32_POLY   32'hedb88320
`define DCS_CRC16_INIT   32'h0000ffff
`define DCS_CRC32_INIT   32'hffffffff

// ==========================================
// Descriptor layout and reset values
`define DCS_BTC_VALID    0
`define DCS_BTC_W_LO     8
`define DCS_BTC_W_HI     9
`define DCS_DESC_SHIFT   4
`define DCS_RST_WORD     32'h00000000
`define DCS_AXI_OKAY     2'h0
`define DCS_AXI_SLVERR   2'h2

`endif

//--- rtl/dcs_crc.sv
// Checksum engine: CCITT-16 or Ethernet-32, up to one word per cycle.
// Assumes the owner pulses start_in when the engine is switched on.
`timescale 1ns/100ps
`include "dcs_cfg.svh"
module dcs_crc (
   input  wire logic        clk_in,   // Clock
   input  wire logic        rst_in,   // Sync reset
   input  wire logic        start_in, // Load seed
   input  wire logic [1:0]  poly_in,  // Polynomial code
   input  wire logic [1:0]  width_in, // Unit width code
   input  wire logic        valid_in, // Data strobe
   input  wire logic [31:0] data_in,  // Data unit
   output logic      [31:0] crc_out   // Running checksum
);
   logic [31:0] next_crc;
   logic        ok;

   // ==========================================
   // Reserved codes leave the checksum alone
   assign ok = valid_in && (poly_in == `DCS_POLY_CCITT || poly_in == `DCS_POLY_ETH)
               && (width_in != `DCS_W_RSVD);

   always_comb
   begin
      int nb;
      logic d;
      logic fb;
      nb = 8 << width_in;
      next_crc = crc_out;
      d = 1'b0;
      fb = 1'b0;
      for (int i = 0; i < 32; i++)
      begin
         if (i < nb)
         begin
            if (poly_in == `DCS_POLY_CCITT)
            begin
               d = data_in[(i / 8) * 8 + 7 - (i % 8)];
               fb = next_crc[15] ^ d;
               next_crc[15:0] = {next_crc[14:0], 1'b0} ^ (fb ? `DCS_CRC16_POLY : 16'h0000);
            end
            else
            begin
               d = data_in[i];
               fb = next_crc[0] ^ d;
               next_crc = (next_crc >> 1) ^ (fb ? `DCS_CRC32_POLY : 32'h00000000);
            end
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         crc_out <= `DCS_RST_WORD;
      else if (start_in)
         crc_out <= (poly_in == `DCS_POLY_CCITT) ? `DCS_CRC16_INIT : `DCS_CRC32_INIT;
      else if (ok)
         crc_out <= next_crc;
   end
endmodule

//--- rtl/dcs_pkg.sv
// Types shared by the channel setup block.
// Constants live in dcs_cfg.svh.
package dcs_pkg;
   typedef enum logic [2:0]
   {
      DCS_IDLE  = 3'b000,
      DCS_FETCH = 3'b001,
      DCS_READ  = 3'b010,
      DCS_WRITE = 3'b011,
      DCS_WBACK = 3'b100
   } dcs_state_t;
   typedef logic [1:0] dcs_chan_t;
endpackage

//--- rtl/dcs_top.sv
// Four-channel transfer controller with descriptor fetch, write-back and checksum.
// Assumes an AXI4-Lite master for registers and a req/ack memory port.
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "dcs_cfg.svh"
module dcs_top (
   input  wire logic        clk_in,           // 10 MHz clock
   input  wire logic        rst_in,           // Sync reset, high
   input  wire logic [7:0]  s_axi_awaddr_in,  // Write address
   input  wire logic        s_axi_awvalid_in, // Write address valid
   output logic             s_axi_awready_out,// Write address ready
   input  wire logic [31:0] s_axi_wdata_in,   // Write data
   input  wire logic [3:0]  s_axi_wstrb_in,   // Byte enables, unused: every write takes the whole word
   input  wire logic        s_axi_wvalid_in,  // Write data valid
   output logic             s_axi_wready_out, // Write data ready
   output logic [1:0]       s_axi_bresp_out,  // Write response
   output logic             s_axi_bvalid_out, // Write response valid
   input  wire logic        s_axi_bready_in,  // Write response ready
   input  wire logic [7:0]  s_axi_araddr_in,  // Read address
   input  wire logic        s_axi_arvalid_in, // Read address valid
   output logic             s_axi_arready_out,// Read address ready
   output logic [31:0]      s_axi_rdata_out,  // Read data
   output logic [1:0]       s_axi_rresp_out,  // Read response
   output logic             s_axi_rvalid_out, // Read data valid
   input  wire logic        s_axi_rready_in,  // Read data ready
   input  wire logic [7:0]  trig_in,          // Peripheral triggers
   output logic             mem_req_out,      // Memory request
   output logic             mem_we_out,       // Memory write
   output logic [31:0]      mem_addr_out,     // Memory address
   output logic [1:0]       mem_size_out,     // Access width code
   output logic [31:0]      mem_wdata_out,    // Memory write data
   input  wire logic        mem_ack_in,       // Memory done
   input  wire logic [31:0] mem_rdata_in      // Memory read data
);
   localparam int NCH = 4;

   logic                transfer_controller_on;
   logic [3:0]          priority_level_enable;
   logic [31:0]         descriptor_base_pointer;
   logic [31:0]         writeback_base_pointer;
   dcs_pkg::dcs_chan_t  chan_sel;
   logic [NCH-1:0]      ch_en, ch_ie, ch_act, act_ld, trig_pend, channel_pending_irq;
   logic [2:0]          ch_src [NCH];
   logic [1:0]          ch_lvl [NCH];
   logic [15:0]         act_cnt [NCH];
   logic [31:0]         act_src [NCH];
   logic [31:0]         act_dst [NCH];
   logic [1:0]          act_w [NCH];
   logic                crc_on, crc_src_dma, crc_start;
   logic [1:0]          crc_poly, crc_w;
   logic [31:0]         crc_sum, beat_data;
   dcs_pkg::dcs_state_t st;
   dcs_pkg::dcs_chan_t  cur, win;
   logic [1:0]          widx;
   logic                fetch_ok, found;
   logic [NCH-1:0]      req;
   logic [7:0]          trg_s1, trg_s2, trg_s3, trg_lvl, trg_rise;
   logic                aw_h, w_h, wr_en, rd_en;
   logic [7:0]          aw_a;
   logic [31:0]         w_d;
   logic [31:0]         inc;
   logic                last_beat, blk_end, crc_dv;
   logic [31:0]         crc_data;
   logic [1:0]          crc_width;

   // ==========================================
   // AXI4-Lite slave
   assign s_axi_awready_out = !aw_h && !s_axi_bvalid_out;
   assign s_axi_wready_out  = !w_h && !s_axi_bvalid_out;
   assign s_axi_arready_out = !s_axi_rvalid_out;
   assign wr_en = aw_h && w_h && !s_axi_bvalid_out;
   assign rd_en = s_axi_arvalid_in && s_axi_arready_out;

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         aw_h <= 1'b0;
         w_h <= 1'b0;
         aw_a <= 8'h00;
         w_d <= `DCS_RST_WORD;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= `DCS_AXI_OKAY;
      end
      else
      begin
         if (s_axi_awvalid_in && s_axi_awready_out)
         begin
            aw_h <= 1'b1;
            aw_a <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && s_axi_wready_out)
         begin
            w_h <= 1'b1;
            w_d <= s_axi_wdata_in;
         end
         if (wr_en)
         begin
            aw_h <= 1'b0;
            w_h <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            case (aw_a)
               `DCS_OFF_CTRL, `DCS_OFF_CRC_CTRL, `DCS_OFF_CRC_DATA, `DCS_OFF_DESC,
               `DCS_OFF_WB, `DCS_OFF_CHCFG, `DCS_OFF_PENDING:
                  s_axi_bresp_out <= `DCS_AXI_OKAY;
               default:
                  s_axi_bresp_out <= `DCS_AXI_SLVERR;
            endcase
         end
         else if (s_axi_bvalid_out && s_axi_bready_in)
            s_axi_bvalid_out <= 1'b0;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= `DCS_RST_WORD;
         s_axi_rresp_out <= `DCS_AXI_OKAY;
      end
      else if (rd_en)
      begin
         s_axi_rvalid_out <= 1'b1;
         s_axi_rresp_out <= `DCS_AXI_OKAY;
         s_axi_rdata_out <= `DCS_RST_WORD;
         case (s_axi_araddr_in)
            `DCS_OFF_CTRL:
               s_axi_rdata_out <= {20'h00000, priority_level_enable, 7'h00,
                                   transfer_controller_on};
            `DCS_OFF_CRC_CTRL:
               s_axi_rdata_out <= {23'h000000, crc_on, 3'h0, crc_src_dma, crc_poly, crc_w};
            `DCS_OFF_CRC_SUM:  s_axi_rdata_out <= crc_sum;
            `DCS_OFF_DESC:     s_axi_rdata_out <= descriptor_base_pointer;
            `DCS_OFF_WB:       s_axi_rdata_out <= writeback_base_pointer;
            `DCS_OFF_CHCFG:
               s_axi_rdata_out <= {6'h00, chan_sel, 6'h00, ch_lvl[chan_sel], 5'h00,
                                   ch_src[chan_sel], 5'h00, ch_act[chan_sel],
                                   ch_ie[chan_sel], ch_en[chan_sel]};
            `DCS_OFF_STATUS:
               s_axi_rdata_out <= {16'h0000, act_ld, ch_en, 2'h0, cur, 3'h0,
                                   st != dcs_pkg::DCS_IDLE};
            `DCS_OFF_PENDING:  s_axi_rdata_out <= {28'h0000000, channel_pending_irq};
            `DCS_OFF_CRC_DATA: s_axi_rdata_out <= `DCS_RST_WORD;
            default:           s_axi_rresp_out <= `DCS_AXI_SLVERR;
         endcase
      end
      else if (s_axi_rvalid_out && s_axi_rready_in)
         s_axi_rvalid_out <= 1'b0;
   end

   // ==========================================
   // Global and checksum control
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         transfer_controller_on <= 1'b0;
         priority_level_enable <= 4'h0;
         descriptor_base_pointer <= `DCS_RST_WORD;
         writeback_base_pointer <= `DCS_RST_WORD;
         crc_on <= 1'b0;
         crc_src_dma <= 1'b0;
         crc_poly <= `DCS_POLY_CCITT;
         crc_w <= `DCS_W_BYTE;
         crc_start <= 1'b0;
      end
      else
      begin
         crc_start <= 1'b0;
         if (wr_en && aw_a == `DCS_OFF_CTRL)
         begin
            transfer_controller_on <= w_d[`DCS_CTRL_ON];
            priority_level_enable <= w_d[`DCS_CTRL_LVL_HI:`DCS_CTRL_LVL_LO];
         end
         if (wr_en && aw_a == `DCS_OFF_DESC && !transfer_controller_on)
            descriptor_base_pointer <= w_d;
         if (wr_en && aw_a == `DCS_OFF_WB && !transfer_controller_on)
            writeback_base_pointer <= w_d;
         if (wr_en && aw_a == `DCS_OFF_CRC_CTRL)
         begin
            crc_on <= w_d[`DCS_CRC_EN];
            crc_src_dma <= w_d[`DCS_CRC_SRC];
            crc_poly <= w_d[`DCS_CRC_P_HI:`DCS_CRC_P_LO];
            crc_w <= w_d[`DCS_CRC_W_HI:`DCS_CRC_W_LO];
            crc_start <= w_d[`DCS_CRC_EN] && !crc_on;
         end
      end
   end

   // ==========================================
   // Trigger synchronisers and edge detect
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         trg_s1 <= 8'h00;
         trg_s2 <= 8'h00;
         trg_s3 <= 8'h00;
         trg_lvl <= 8'h00;
      end
      else
      begin
         trg_s1 <= trig_in;
         trg_s2 <= trg_s1;
         trg_s3 <= trg_s2;
         trg_lvl <= (trg_s2 & trg_s3) | (trg_lvl & (trg_s2 | trg_s3));
      end
   end
   assign trg_rise = (trg_s2 & trg_s3) & ~trg_lvl;

   // ==========================================
   // Arbiter: highest enabled level, then lowest channel
   always_comb
   begin
      win = 2'h0;
      found = 1'b0;
      for (int c = 0; c < NCH; c++)
      begin
         req[c] = ch_en[c] && trig_pend[c] && priority_level_enable[ch_lvl[c]];
         if (req[c] && (!found || ch_lvl[c] > ch_lvl[win]))
         begin
            win = 2'(c);
            found = 1'b1;
         end
      end
   end

   // ==========================================
   // Transfer sequencer
   always_comb
   begin
      case (act_w[cur])
         `DCS_W_BYTE: inc = 32'h00000001;
         `DCS_W_HALF: inc = 32'h00000002;
         default:     inc = 32'h00000004;
      endcase
   end
   assign last_beat = act_cnt[cur] == 16'h0001;
   assign blk_end = act_cnt[cur] == 16'h0000;

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         st <= dcs_pkg::DCS_IDLE;
         cur <= 2'h0;
         widx <= 2'h0;
         fetch_ok <= 1'b0;
         beat_data <= `DCS_RST_WORD;
      end
      else
         case (st)
            dcs_pkg::DCS_IDLE:
               if (transfer_controller_on && found)
               begin
                  cur <= win;
                  widx <= 2'h0;
                  st <= act_ld[win] ? dcs_pkg::DCS_READ : dcs_pkg::DCS_FETCH;
               end
            dcs_pkg::DCS_FETCH:
               if (mem_ack_in)
               begin
                  widx <= widx + 2'h1;
                  if (widx == 2'h0)
                     fetch_ok <= mem_rdata_in[`DCS_BTC_VALID];
                  if (widx == 2'h3)
                  begin
                     widx <= 2'h0;
                     if (!fetch_ok)
                        st <= dcs_pkg::DCS_IDLE;
                     else if (act_cnt[cur] == 16'h0000)
                        st <= dcs_pkg::DCS_WBACK;
                     else
                        st <= dcs_pkg::DCS_READ;
                  end
               end
            dcs_pkg::DCS_READ:
               if (mem_ack_in)
               begin
                  beat_data <= mem_rdata_in;
                  st <= dcs_pkg::DCS_WRITE;
               end
            dcs_pkg::DCS_WRITE:
               if (mem_ack_in)
                  st <= (last_beat || ch_act[cur]) ? dcs_pkg::DCS_WBACK
                                                    : dcs_pkg::DCS_READ;
            dcs_pkg::DCS_WBACK:
               if (mem_ack_in)
               begin
                  widx <= widx + 2'h1;
                  if (widx == 2'h3)
                     st <= dcs_pkg::DCS_IDLE;
               end
            default:
               st <= dcs_pkg::DCS_IDLE;
         endcase
   end

   // ==========================================
   // Memory port
   assign mem_req_out = st != dcs_pkg::DCS_IDLE;
   assign mem_we_out = st == dcs_pkg::DCS_WRITE || st == dcs_pkg::DCS_WBACK;
   always_comb
   begin
      mem_size_out = `DCS_W_WORD;
      mem_wdata_out = `DCS_RST_WORD;
      case (st)
         dcs_pkg::DCS_FETCH:
            mem_addr_out = descriptor_base_pointer + {26'h0000000, cur, widx, 2'h0};
         dcs_pkg::DCS_READ:
         begin
            mem_addr_out = act_src[cur];
            mem_size_out = act_w[cur];
         end
         dcs_pkg::DCS_WRITE:
         begin
            mem_addr_out = act_dst[cur];
            mem_size_out = act_w[cur];
            mem_wdata_out = beat_data;
         end
         dcs_pkg::DCS_WBACK:
         begin
            mem_addr_out = writeback_base_pointer + {26'h0000000, cur, widx, 2'h0};
            case (widx)
               2'h0: mem_wdata_out = {22'h000000, act_w[cur], 7'h00, !blk_end};
               2'h1: mem_wdata_out = {16'h0000, act_cnt[cur]};
               2'h2: mem_wdata_out = act_src[cur];
               default: mem_wdata_out = act_dst[cur];
            endcase
         end
         default:
            mem_addr_out = `DCS_RST_WORD;
      endcase
   end

   // ==========================================
   // Channel configuration and working state
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         chan_sel <= 2'h0;
         ch_en <= '0;
         ch_ie <= '0;
         ch_act <= '0;
         act_ld <= '0;
         trig_pend <= '0;
         channel_pending_irq <= '0;
         for (int c = 0; c < NCH; c++)
         begin
            ch_src[c] <= 3'h0;
            ch_lvl[c] <= 2'h0;
            act_cnt[c] <= 16'h0000;
            act_src[c] <= `DCS_RST_WORD;
            act_dst[c] <= `DCS_RST_WORD;
            act_w[c] <= `DCS_W_BYTE;
         end
      end
      else
      begin
         for (int c = 0; c < NCH; c++)
         begin
            if (st == dcs_pkg::DCS_IDLE && transfer_controller_on && found && win == 2'(c))
               trig_pend[c] <= 1'b0;
            if (ch_en[c] && trg_rise[ch_src[c]])
               trig_pend[c] <= 1'b1;
            if (wr_en && aw_a == `DCS_OFF_PENDING && w_d[c])
               channel_pending_irq[c] <= 1'b0;
            if (!ch_ie[c])
               channel_pending_irq[c] <= 1'b0;
         end
         if (st == dcs_pkg::DCS_FETCH && mem_ack_in)
            case (widx)
               2'h0: act_w[cur] <= mem_rdata_in[`DCS_BTC_W_HI:`DCS_BTC_W_LO];
               2'h1: act_cnt[cur] <= mem_rdata_in[15:0];
               2'h2: act_src[cur] <= mem_rdata_in;
               default:
               begin
                  act_dst[cur] <= mem_rdata_in;
                  act_ld[cur] <= fetch_ok;
               end
            endcase
         if (st == dcs_pkg::DCS_WRITE && mem_ack_in)
         begin
            act_cnt[cur] <= act_cnt[cur] - 16'h0001;
            act_src[cur] <= act_src[cur] + inc;
            act_dst[cur] <= act_dst[cur] + inc;
         end
         if (st == dcs_pkg::DCS_WBACK && mem_ack_in && widx == 2'h3 && blk_end)
         begin
            act_ld[cur] <= 1'b0;
            ch_en[cur] <= 1'b0;
            if (ch_ie[cur])
               channel_pending_irq[cur] <= 1'b1;
         end
         if (wr_en && aw_a == `DCS_OFF_CHCFG)
         begin
            chan_sel <= w_d[`DCS_CCA_SEL_HI:`DCS_CCA_SEL_LO];
            ch_en[w_d[`DCS_CCA_SEL_HI:`DCS_CCA_SEL_LO]] <= w_d[`DCS_CCA_EN];
            ch_ie[w_d[`DCS_CCA_SEL_HI:`DCS_CCA_SEL_LO]] <= w_d[`DCS_CCA_IE];
            ch_act[w_d[`DCS_CCA_SEL_HI:`DCS_CCA_SEL_LO]] <= w_d[`DCS_CCA_ACT];
            ch_src[w_d[`DCS_CCA_SEL_HI:`DCS_CCA_SEL_LO]] <=
               w_d[`DCS_CCA_SRC_HI:`DCS_CCA_SRC_LO];
            ch_lvl[w_d[`DCS_CCA_SEL_HI:`DCS_CCA_SEL_LO]] <=
               w_d[`DCS_CCA_LVL_HI:`DCS_CCA_LVL_LO];
            if (!w_d[`DCS_CCA_EN])
               act_ld[w_d[`DCS_CCA_SEL_HI:`DCS_CCA_SEL_LO]] <= 1'b0;
         end
      end
   end

   // ==========================================
   // Checksum feed
   assign crc_dv = crc_on && (crc_src_dma ? (st == dcs_pkg::DCS_READ && mem_ack_in)
                                        : (wr_en && aw_a == `DCS_OFF_CRC_DATA));
   assign crc_data = crc_src_dma ? mem_rdata_in : w_d;
   assign crc_width = crc_src_dma ? act_w[cur] : crc_w;

   dcs_crc u_crc (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .start_in (crc_start),
      .poly_in  (crc_poly),
      .width_in (crc_width),
      .valid_in (crc_dv),
      .data_in  (crc_data),
      .crc_out  (crc_sum)
   );
endmodule
